// ### gtdc_defines.svh
`ifndef GTDC_DEFINES_SVH
`define GTDC_DEFINES_SVH
`define GTDC_CNT_W       16
`define GTDC_CNT_RST     16'h0000
`define GTDC_CNT_ONES    16'hFFFF
`define GTDC_CNT_ZERO    16'h0000
`define GTDC_MODE_LO     0
`define GTDC_MODE_HI     1
`define GTDC_NCH         5
`define GTDC_DIV8_CNT    3'h7
`define GTDC_DIV32_CNT   5'h1F
`endif

// ### gtdc_pkg.sv
package gtdc_pkg;
	typedef enum logic [1:0] {
		GTDC_TIMER,
		GTDC_EVENT,
		GTDC_ONESHOT,
		GTDC_PWM
	} gtdc_mode_e;
	typedef enum logic [1:0] {
		GTDC_SRC_DIV1,
		GTDC_SRC_DIV8,
		GTDC_SRC_DIV32,
		GTDC_SRC_SUB32
	} gtdc_src_e;
endpackage

// ### gtdc_timer.sv
`timescale 1ns/10ps
`include "gtdc_defines.svh"
// Function
// - Independent channels, each a 16-bit counter
// - Channels identical outside event counting
// - Mode chosen by mode bits 0 and 1
// - One-shot stops at the first underflow, one source pulse after count reaches zero
// - Timer source: div1, div8, div32, sub32
// - Count down, reload on underflow, continue
// - One underflow per n+1 source pulses
// - Count while start flag set, halt cleared
// - Interrupt request on every underflow
// - Live read; reload-moment read gives all ones
// - Halted write reads back correctly
// - Halted write loads reload and counter
// - Running write loads reload register only
// - Gate pin level starts and stops counting
// - Pulse output toggles at every underflow
// - Two-phase event request accepted on last three (flag only, counting stays single-edge)
module gtdc_timer
	import gtdc_pkg::*;
#(
	parameter int CH = 0                         // Channel index, two-phase allowed when >= 2
) (
	input  wire logic        CLK,               // System clock, 100 MHz
	input  wire logic        RESET,             // Async reset, active high
	input  wire logic [1:0]  MODE_SEL,          // Operating mode
	input  wire logic [1:0]  SRC_SEL,           // Count source select
	input  wire logic        COUNT_START,       // Count start flag
	input  wire logic        GATE_EN,           // Gate function enable
	input  wire logic        GATE_HIGH,         // Gate counts while pin high when set
	input  wire logic        PULSE_EN,          // Pulse output enable
	input  wire logic        TWO_PHASE,         // Two-phase event request
	input  wire logic        SUBCLK_DIV32_TICK, // Sub-clock divided by 32, pin-side pulse
	input  wire logic        EVENT_IN,          // External event input
	input  wire logic        CHANNEL_GATE_INPUT_PIN, // Gate input pin
	input  wire logic        WR_EN,             // Timer register write strobe
	input  wire logic [15:0] WR_DATA,           // Timer register write data
	output logic [15:0]      RD_DATA,           // Timer register read value
	output logic             IRQ,               // Underflow interrupt pulse
	output logic             CHANNEL_PULSE_OUTPUT_PIN, // Toggling pulse output
	output logic             TWO_PHASE_OK       // Two-phase mode accepted
);
	// Counter, reload and read-back registers
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic [15:0] rld_ff;
	logic [15:0] nxt_rld;
	logic [15:0] rd_ff;
	logic [15:0] nxt_rd;
	// Free-running prescalers
	logic [2:0]  div8_ff;
	logic [2:0]  nxt_div8;
	logic [4:0]  div32_ff;
	logic [4:0]  nxt_div32;
	// Output and run state
	logic        irq_ff;
	logic        nxt_irq;
	logic        out_ff;
	logic        nxt_out;
	logic        run_ff;
	logic        nxt_run;
	logic        tp_ff;
	logic        nxt_tp;
	// Pin synchroniser stages
	logic        g1_ff;
	logic        g2_ff;
	logic        s1_ff;
	logic        s2_ff;
	logic        s3_ff;
	logic        e1_ff;
	logic        e2_ff;
	logic        e3_ff;
	// Decoded count conditions
	logic        tick;
	logic        gate_ok;
	logic        counting;
	logic        uflow;
	gtdc_mode_e  mode;

	assign mode = gtdc_mode_e'(MODE_SEL[`GTDC_MODE_HI:`GTDC_MODE_LO]);

	// Pin synchronisers
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			g1_ff <= 1'b0;
			g2_ff <= 1'b0;
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			e1_ff <= 1'b0;
			e2_ff <= 1'b0;
			e3_ff <= 1'b0;
		end else begin
			g1_ff <= CHANNEL_GATE_INPUT_PIN;
			g2_ff <= g1_ff;
			s1_ff <= SUBCLK_DIV32_TICK;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			e1_ff <= EVENT_IN;
			e2_ff <= e1_ff;
			e3_ff <= e2_ff;
		end
	end

	// Source selection and gating
	always_comb begin
		case (gtdc_src_e'(SRC_SEL))
			GTDC_SRC_DIV1:  tick = 1'b1;
			GTDC_SRC_DIV8:  tick = (div8_ff == `GTDC_DIV8_CNT);
			GTDC_SRC_DIV32: tick = (div32_ff == `GTDC_DIV32_CNT);
			GTDC_SRC_SUB32: tick = s2_ff & ~s3_ff;
			default:        tick = 1'b0;
		endcase
		// Event mode replaces the internal source with the synced pin edge
		if (mode == GTDC_EVENT) begin
			tick = e2_ff & ~e3_ff;
		end
		gate_ok  = !GATE_EN || (g2_ff == GATE_HIGH);
		counting = COUNT_START && gate_ok && run_ff;
		uflow    = counting && tick && (cnt_ff == `GTDC_CNT_ZERO);
	end

	// Next values: writes first, then counting may override the counter
	always_comb begin
		nxt_div8  = div8_ff + 3'h1;
		nxt_div32 = div32_ff + 5'h01;
		nxt_cnt   = cnt_ff;
		nxt_rld   = rld_ff;
		nxt_irq   = 1'b0;
		nxt_out   = out_ff;
		nxt_run   = run_ff;
		nxt_tp    = (CH >= 2) && TWO_PHASE && (mode == GTDC_EVENT);
		if (!COUNT_START) begin
			nxt_run = 1'b1;
		end
		if (WR_EN) begin
			nxt_rld = WR_DATA;
			if (!COUNT_START) begin
				nxt_cnt = WR_DATA;
			end
		end
		if (counting && tick) begin
			if (uflow) begin
				nxt_irq = 1'b1;
				if (PULSE_EN) begin
					nxt_out = ~out_ff;
				end
				if (mode == GTDC_ONESHOT) begin
					nxt_run = 1'b0;
				end else begin
					nxt_cnt = nxt_rld;
				end
			end else begin
				nxt_cnt = cnt_ff - 16'h0001;
			end
		end
		// A read at the reload moment shows all ones, even over a write
		if (uflow) begin
			nxt_rd = `GTDC_CNT_ONES;
		end else if (!COUNT_START && WR_EN) begin
			nxt_rd = WR_DATA;
		end else begin
			nxt_rd = nxt_cnt;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cnt_ff  <= `GTDC_CNT_RST;
			rld_ff  <= `GTDC_CNT_RST;
			rd_ff   <= `GTDC_CNT_RST;
			div8_ff <= 3'h0;
			div32_ff <= 5'h00;
			irq_ff  <= 1'b0;
			out_ff  <= 1'b0;
			run_ff  <= 1'b1;
			tp_ff   <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			rld_ff  <= nxt_rld;
			rd_ff   <= nxt_rd;
			div8_ff <= nxt_div8;
			div32_ff <= nxt_div32;
			irq_ff  <= nxt_irq;
			out_ff  <= nxt_out;
			run_ff  <= nxt_run;
			tp_ff   <= nxt_tp;
		end
	end

	assign RD_DATA                  = rd_ff;
	assign IRQ                      = irq_ff;
	assign CHANNEL_PULSE_OUTPUT_PIN = out_ff;
	assign TWO_PHASE_OK             = tp_ff;

	stop_write_a: assert property (@(posedge CLK) disable iff (RESET)
		WR_EN && !COUNT_START |=> cnt_ff == $past(WR_DATA) && rld_ff == $past(WR_DATA))
		else $error("halted write did not load counter");
	run_write_a: assert property (@(posedge CLK) disable iff (RESET)
		WR_EN && COUNT_START && !uflow |=> rld_ff == $past(WR_DATA))
		else $error("running write did not load reload");
	uflow_irq_a: assert property (@(posedge CLK) disable iff (RESET)
		uflow |=> IRQ)
		else $error("underflow missed interrupt");
	irq_cause_a: assert property (@(posedge CLK) disable iff (RESET)
		!uflow |=> !IRQ)
		else $error("interrupt without underflow");
	reload_val_a: assert property (@(posedge CLK) disable iff (RESET)
		uflow && mode != GTDC_ONESHOT && !WR_EN |=> cnt_ff == $past(rld_ff))
		else $error("reload value wrong");
	read_ones_a: assert property (@(posedge CLK) disable iff (RESET)
		uflow |=> RD_DATA == `GTDC_CNT_ONES)
		else $error("reload read not all ones");
	pulse_tog_a: assert property (@(posedge CLK) disable iff (RESET)
		uflow && PULSE_EN |=> CHANNEL_PULSE_OUTPUT_PIN != $past(CHANNEL_PULSE_OUTPUT_PIN))
		else $error("pulse output not toggled");
	halt_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		!COUNT_START && !WR_EN |=> cnt_ff == $past(cnt_ff))
		else $error("counter moved while halted");
	oneshot_stop_a: assert property (@(posedge CLK) disable iff (RESET)
		uflow && mode == GTDC_ONESHOT |=> !run_ff)
		else $error("one-shot kept running");
	gate_stop_a: assert property (@(posedge CLK) disable iff (RESET)
		!gate_ok && !WR_EN |=> cnt_ff == $past(cnt_ff))
		else $error("counted with gate closed");

	// Counting and reload
	count_dec_a: assert property (@(posedge CLK) disable iff (RESET)
		counting && tick && !uflow |=> cnt_ff == $past(cnt_ff) - 16'h0001)
		else $error("counter did not step down");

	rld_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		!WR_EN |=> rld_ff == $past(rld_ff))
		else $error("reload changed without write");

	oneshot_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		!run_ff && COUNT_START && !WR_EN |=> cnt_ff == $past(cnt_ff))
		else $error("stopped one-shot moved");

	rearm_a: assert property (@(posedge CLK) disable iff (RESET)
		!COUNT_START |=> run_ff)
		else $error("halt did not re-arm");

	// Count sources
	div8_wrap_a: assert property (@(posedge CLK) disable iff (RESET)
		div8_ff == `GTDC_DIV8_CNT |=> div8_ff == 3'h0)
		else $error("divide-by-8 did not wrap");

	div32_wrap_a: assert property (@(posedge CLK) disable iff (RESET)
		div32_ff == `GTDC_DIV32_CNT |=> div32_ff == 5'h00)
		else $error("divide-by-32 did not wrap");

	sub_src_a: assert property (@(posedge CLK) disable iff (RESET)
		mode != GTDC_EVENT && SRC_SEL == 2'h3 && !(s2_ff && !s3_ff) && !WR_EN |=> cnt_ff == $past(cnt_ff))
		else $error("sub-clock source counted without edge");

	event_src_a: assert property (@(posedge CLK) disable iff (RESET)
		mode == GTDC_EVENT && !(e2_ff && !e3_ff) && !WR_EN |=> cnt_ff == $past(cnt_ff))
		else $error("event mode counted without edge");

	// Read-back and pins
	rd_live_a: assert property (@(posedge CLK) disable iff (RESET)
		!uflow |=> RD_DATA == cnt_ff)
		else $error("read value not live counter");

	halt_read_a: assert property (@(posedge CLK) disable iff (RESET)
		WR_EN && !COUNT_START |=> RD_DATA == $past(WR_DATA))
		else $error("halted write not read back");

	out_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		!uflow |=> $stable(CHANNEL_PULSE_OUTPUT_PIN))
		else $error("pulse output moved without underflow");

	pulse_off_a: assert property (@(posedge CLK) disable iff (RESET)
		uflow && !PULSE_EN |=> $stable(CHANNEL_PULSE_OUTPUT_PIN))
		else $error("pulse output toggled while disabled");

	tp_chan_a: assert property (@(posedge CLK) disable iff (RESET)
		TWO_PHASE_OK |-> CH >= 2)
		else $error("two-phase accepted on single-phase channel");

	tp_req_a: assert property (@(posedge CLK) disable iff (RESET)
		!TWO_PHASE |=> !TWO_PHASE_OK)
		else $error("two-phase accepted without request");

	uflow_c: cover property (@(posedge CLK) disable iff (RESET) uflow ##1 IRQ);
	oneshot_c: cover property (@(posedge CLK) disable iff (RESET) uflow && mode == GTDC_ONESHOT ##1 !run_ff);
	event_c: cover property (@(posedge CLK) disable iff (RESET) mode == GTDC_EVENT && uflow);
	write_run_c: cover property (@(posedge CLK) disable iff (RESET) WR_EN && COUNT_START ##[1:40] uflow);
	gate_c: cover property (@(posedge CLK) disable iff (RESET) GATE_EN && !gate_ok ##1 gate_ok);
endmodule

// ### gtdc_timer_bench.sv
`timescale 1ns/10ps
module gtdc_timer_bench;
	import gtdc_pkg::*;
	logic        clk, reset, count_start, gate_en, gate_high, pulse_en, gate_pin, wr_en, irq, pulse_pin, saw_ones, pin_a;
	logic [1:0]  src_sel, mode_sel;
	logic        two_phase, event_in, tp_ok;
	logic [15:0] wr_data, rd_data;
	int          err_count = 0;
	int          checked = 0;
	int          per;
	gtdc_timer #(.CH(0)) gtdc_timer_i (
		.CLK(clk), .RESET(reset), .MODE_SEL(mode_sel), .SRC_SEL(src_sel), .COUNT_START(count_start),
		.GATE_EN(gate_en), .GATE_HIGH(gate_high), .PULSE_EN(pulse_en), .TWO_PHASE(two_phase),
		.SUBCLK_DIV32_TICK(1'b0), .EVENT_IN(event_in), .CHANNEL_GATE_INPUT_PIN(gate_pin), .WR_EN(wr_en),
		.WR_DATA(wr_data), .RD_DATA(rd_data), .IRQ(irq), .CHANNEL_PULSE_OUTPUT_PIN(pulse_pin), .TWO_PHASE_OK(tp_ok)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic write_tmr(logic [15:0] d);
		wr_en = 1'b1;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	// Cycles up to the next underflow pulse, capped at 50
	task automatic wait_irq();
		per = 0;
		saw_ones = 1'b0;
		do begin
			@(negedge clk);
			per++;
			if (rd_data === 16'hFFFF) saw_ones = 1'b1;
		end while (irq !== 1'b1 && per < 50);
	endtask
	initial begin
		reset = 1'b1;
		src_sel = GTDC_SRC_DIV1;
		{count_start, gate_en, gate_high, pulse_en, gate_pin, wr_en} = 6'h0C;
		mode_sel = 2'h0;
		two_phase = 1'b0;
		event_in = 1'b0;
		wr_data = 16'h0000;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		write_tmr(16'h0002);
		chk("halted readback", rd_data, 16'h0002);
		$display("test halted write done");
		count_start = 1'b1;
		wait_irq();
		pin_a = pulse_pin;
		wait_irq();
		chk("div1 period", 16'(per), 16'h0003);
		chk("pulse toggle", {15'h0000, pulse_pin}, {15'h0000, ~pin_a});
		chk("reload read", {15'h0000, saw_ones}, 16'h0001);
		$display("test timer period done");
		write_tmr(16'h0005);
		wait_irq();
		wait_irq();
		chk("running write period", 16'(per), 16'h0006);
		$display("test running write done");
		count_start = 1'b0;
		wait_irq();
		chk("halted no underflow", 16'(per), 16'h0032);
		count_start = 1'b1;
		gate_en = 1'b1;
		wait_irq();
		chk("gate closed", 16'(per), 16'h0032);
		gate_pin = 1'b1;
		wait_irq();
		wait_irq();
		chk("gate open period", 16'(per), 16'h0006);
		$display("test gate done");
		gate_en = 1'b0;
		for (int s = 1; s < 3; s++) begin
			count_start = 1'b0;
			write_tmr(16'h0000);
			src_sel = 2'(s);
			count_start = 1'b1;
			wait_irq();
			wait_irq();
			chk("prescaled period", 16'(per), (s == 1) ? 16'h0008 : 16'h0020);
		end
		$display("test prescaler done");
		count_start = 1'b0;
		mode_sel = 2'h2;
		src_sel = GTDC_SRC_DIV1;
		write_tmr(16'h0003);
		count_start = 1'b1;
		wait_irq();
		chk("one-shot period", 16'(per), 16'h0004);
		wait_irq();
		chk("one-shot stopped", 16'(per), 16'h0032);
		chk("one-shot value", rd_data, 16'h0000);
		$display("test one-shot done");
		count_start = 1'b0;
		mode_sel = 2'h1;
		two_phase = 1'b1;
		write_tmr(16'h0001);
		count_start = 1'b1;
		event_in = 1'b1;
		repeat (4) @(negedge clk);
		chk("event count", rd_data, 16'h0000);
		event_in = 1'b0;
		repeat (3) @(negedge clk);
		event_in = 1'b1;
		wait_irq();
		chk("event underflow", {15'h0000, irq}, 16'h0001);
		chk("two-phase refused", {15'h0000, tp_ok}, 16'h0000);
		$display("test event done");
		summarize();
	end
	initial begin
		#100000;
		err_count++;
		summarize();
	end
endmodule
